// [design/prd_pkg.sv]
// Address map, reset values and field positions of the peripheral register bank
package prd_pkg;
  // ----------------------------------------------------------------
  // Address windows
  // ----------------------------------------------------------------
  localparam logic [31:0] PRD_PERIPH_BASE = 32'h0320_0000;
  localparam logic [31:0] PRD_PERIPH_LAST = 32'h0320_01F8;
  localparam logic [31:0] PRD_VS_BASE = 32'h0340_0000;
  localparam logic [31:0] PRD_VS_LAST = 32'h034F_FFFF;
  localparam int PRD_OFS_W = 9;
  localparam int PRD_IDX_W = 7;
  localparam int PRD_NUM_WORDS = 128;
  localparam int PRD_VS_SEL_MSB = 31;
  localparam int PRD_VS_SEL_LSB = 24;
  localparam int PRD_REG_W = 8;
  localparam int PRD_CNT_W = 16;
  localparam int PRD_NUM_TIMERS = 2;

  // ----------------------------------------------------------------
  // Register byte offsets from the peripheral base
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_IO_CONTROL = 9'h000;
  localparam logic [8:0] OFS_KEYBOARD_DATA = 9'h004;
  localparam logic [8:0] OFS_KEYBOARD_CONTROL = 9'h008;
  localparam logic [8:0] OFS_GENERAL_IO_LINES = 9'h00C;
  localparam logic [8:0] OFS_IRQ_A_STATUS = 9'h010;
  localparam logic [8:0] OFS_IRQ_A_REQUEST_CLEAR = 9'h014;
  localparam logic [8:0] OFS_IRQ_A_MASK = 9'h018;
  localparam logic [8:0] OFS_SUSPEND_ENTRY = 9'h01C;
  localparam logic [8:0] OFS_IRQ_B_STATUS = 9'h020;
  localparam logic [8:0] OFS_IRQ_B_REQUEST = 9'h024;
  localparam logic [8:0] OFS_IRQ_B_MASK = 9'h028;
  localparam logic [8:0] OFS_STOP_ENTRY = 9'h02C;
  localparam logic [8:0] OFS_FAST_IRQ_STATUS = 9'h030;
  localparam logic [8:0] OFS_FAST_IRQ_REQUEST = 9'h034;
  localparam logic [8:0] OFS_FAST_IRQ_MASK = 9'h038;
  localparam logic [8:0] OFS_TIMER0_COUNT_LOW = 9'h040;
  localparam logic [8:0] OFS_TIMER0_COUNT_HIGH = 9'h044;
  localparam logic [8:0] OFS_TIMER0_GO_CMD = 9'h048;
  localparam logic [8:0] OFS_TIMER0_LATCH_CMD = 9'h04C;
  localparam logic [8:0] OFS_TIMER1_COUNT_LOW = 9'h050;
  localparam logic [8:0] OFS_TIMER1_COUNT_HIGH = 9'h054;
  localparam logic [8:0] OFS_TIMER1_GO_CMD = 9'h058;
  localparam logic [8:0] OFS_TIMER1_LATCH_CMD = 9'h05C;
  localparam logic [8:0] OFS_IRQ_C_STATUS = 9'h060;
  localparam logic [8:0] OFS_IRQ_C_REQUEST = 9'h064;
  localparam logic [8:0] OFS_IRQ_C_MASK = 9'h068;
  localparam logic [8:0] OFS_LCD_SERIAL_AUDIO_SELECT = 9'h06C;
  localparam logic [8:0] OFS_IRQ_D_STATUS = 9'h070;
  localparam logic [8:0] OFS_IRQ_D_REQUEST = 9'h074;
  localparam logic [8:0] OFS_IRQ_D_MASK = 9'h078;
  localparam logic [8:0] OFS_ROM_BANK0_CONTROL = 9'h080;
  localparam logic [8:0] OFS_ROM_BANK1_CONTROL = 9'h084;
  localparam logic [8:0] OFS_REFRESH_PERIOD = 9'h08C;
  localparam logic [8:0] OFS_CHIP_IDENT_LOW = 9'h094;
  localparam logic [8:0] OFS_CHIP_IDENT_HIGH = 9'h098;
  localparam logic [8:0] OFS_CHIP_REVISION = 9'h09C;
  localparam logic [8:0] OFS_POINTER_PORT_DATA = 9'h0A8;
  localparam logic [8:0] OFS_POINTER_PORT_CONTROL = 9'h0AC;
  localparam logic [8:0] OFS_IO_CYCLE_TIMING = 9'h0C4;
  localparam logic [8:0] OFS_EXPANSION_CARD_TIMING = 9'h0C8;
  localparam logic [8:0] OFS_ASYNC_IO_TIMING = 9'h0CC;
  localparam logic [8:0] OFS_DRAM_CONTROL = 9'h0D0;
  localparam logic [8:0] OFS_ADC_INTERRUPT_CONTROL = 9'h0E0;
  localparam logic [8:0] OFS_ADC_STATUS = 9'h0E4;
  localparam logic [8:0] OFS_ADC_CONVERTER_CONTROL = 9'h0E8;
  localparam logic [8:0] OFS_ADC_COUNTER_ONE = 9'h0EC;
  localparam logic [8:0] OFS_ADC_COUNTER_TWO = 9'h0F0;
  localparam logic [8:0] OFS_ADC_COUNTER_THREE = 9'h0F4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRD_IO_CONTROL_RST = 8'h0B;
  localparam logic [7:0] PRD_IO_LINES_RST = 8'hFF;
  localparam logic [7:0] PRD_REG_RST = 8'h00;
  localparam logic [15:0] PRD_CNT_RST = 16'h0000;
  localparam logic [15:0] PRD_CNT_ONE = 16'h0001;
  localparam logic [31:0] PRD_WORD_ZERO = 32'h0000_0000;
endpackage

// [design/prd_regbank.sv]
// Peripheral register bank: address decode, storage, commands and timers
//
// Contract
// RQ1: Writes to the video and sound window drive the macrocell register strobe.
// RQ2: Macrocell target register comes from the top data bits, not the address.
// RQ3: Macrocell registers are write only; reads there return zero.
// RQ4: Master writes whole 32-bit words within the peripheral window.
// RQ5: Registers are word aligned; only the low data bits are kept.
// RQ6: Register offsets are displacements from the peripheral base address.
// RQ7: Writing the suspend register requests suspend; the register reads back.
// RQ8: Writing the stop register requests stop; it is never read.
// RQ9: Timer go writes start that timer and store nothing readable.
// RQ10: Timer latch writes capture the current count for later reads.
// RQ11: Software avoids forbidden directions on status and command registers.
// RQ12: Unassigned offsets ignore writes and read as zero.
module prd_regbank
  import prd_pkg::*;
#(
  parameter logic [7:0] IDENT_LOW = 8'h5A,  // arbitrary value
  parameter logic [7:0] IDENT_HIGH = 8'hA5,  // arbitrary value
  parameter logic [7:0] REVISION = 8'h01  // arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  output logic bus_rvalid_out,
  input wire logic [7:0] irq_a_status_in,
  input wire logic [7:0] irq_b_status_in,
  input wire logic [7:0] irq_c_status_in,
  input wire logic [7:0] irq_d_status_in,
  input wire logic [7:0] fast_irq_status_in,
  input wire logic [7:0] adc_status_in,
  input wire logic [15:0] adc_count_one_in,
  input wire logic [15:0] adc_count_two_in,
  input wire logic [15:0] adc_count_three_in,
  output logic vs_wr_out,
  output logic [7:0] vs_sel_out,
  output logic [31:0] vs_data_out,
  output logic [7:0] irq_a_clear_out,
  output logic irq_pending_out,
  output logic fast_irq_pending_out,
  output logic suspend_req_out,
  output logic stop_req_out,
  output logic [1:0] timer_tick_out,
  output logic [7:0] io_control_out,
  output logic [7:0] io_lines_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] low_byte(input logic [31:0] w);
    return w[PRD_REG_W-1:0];
  endfunction

  wire logic [8:0] ofs = bus_addr_in[PRD_OFS_W-1:0];
  wire logic [6:0] idx = bus_addr_in[PRD_OFS_W-1:2];
  wire logic aligned = (bus_addr_in[1:0] == 2'b00);
  wire logic in_periph = (bus_addr_in >= PRD_PERIPH_BASE) &&
                         (bus_addr_in <= PRD_PERIPH_LAST) && aligned;  // RQ6
  wire logic in_vs = (bus_addr_in >= PRD_VS_BASE) && (bus_addr_in <= PRD_VS_LAST);  // RQ1
  wire logic wr_p = bus_wr_in && in_periph;
  wire logic rd_p = bus_rd_in && in_periph;
  wire logic wr_vs = bus_wr_in && in_vs;

  // Registers that store what software writes
  logic is_rw;
  always_comb begin
    case (ofs)
      OFS_IO_CONTROL, OFS_KEYBOARD_DATA, OFS_KEYBOARD_CONTROL, OFS_GENERAL_IO_LINES,
      OFS_IRQ_A_MASK, OFS_SUSPEND_ENTRY, OFS_IRQ_B_MASK, OFS_FAST_IRQ_MASK,
      OFS_TIMER0_COUNT_LOW, OFS_TIMER0_COUNT_HIGH, OFS_TIMER1_COUNT_LOW,
      OFS_TIMER1_COUNT_HIGH, OFS_IRQ_C_MASK, OFS_LCD_SERIAL_AUDIO_SELECT,
      OFS_IRQ_D_MASK, OFS_ROM_BANK0_CONTROL, OFS_ROM_BANK1_CONTROL,
      OFS_REFRESH_PERIOD, OFS_POINTER_PORT_DATA, OFS_POINTER_PORT_CONTROL,
      OFS_IO_CYCLE_TIMING, OFS_EXPANSION_CARD_TIMING, OFS_ASYNC_IO_TIMING,
      OFS_DRAM_CONTROL, OFS_ADC_INTERRUPT_CONTROL, OFS_ADC_CONVERTER_CONTROL: begin
        is_rw = 1'b1;
      end
      default: begin
        is_rw = 1'b0;  // RQ12
      end
    endcase
  end

  wire logic wr_store = wr_p && is_rw;  // RQ12
  wire logic wr_suspend = wr_p && (ofs == OFS_SUSPEND_ENTRY);
  wire logic wr_stop = wr_p && (ofs == OFS_STOP_ENTRY);
  wire logic wr_irq_a_clear = wr_p && (ofs == OFS_IRQ_A_REQUEST_CLEAR);
  wire logic [1:0] wr_go = {wr_p && (ofs == OFS_TIMER1_GO_CMD),
                            wr_p && (ofs == OFS_TIMER0_GO_CMD)};
  wire logic [1:0] wr_latch = {wr_p && (ofs == OFS_TIMER1_LATCH_CMD),
                               wr_p && (ofs == OFS_TIMER0_LATCH_CMD)};

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] regs [PRD_NUM_WORDS];

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < PRD_NUM_WORDS; i++) begin
        regs[i] <= PRD_REG_RST;
      end
      regs[OFS_IO_CONTROL[8:2]] <= PRD_IO_CONTROL_RST;
      regs[OFS_GENERAL_IO_LINES[8:2]] <= PRD_IO_LINES_RST;
    end else if (wr_store) begin
      regs[idx] <= low_byte(bus_wdata_in);  // RQ5
    end
  end

  assign io_control_out = regs[OFS_IO_CONTROL[8:2]];
  assign io_lines_out = regs[OFS_GENERAL_IO_LINES[8:2]];

  // Request views: status gated by the mask registers
  wire logic [7:0] req_a = irq_a_status_in & regs[OFS_IRQ_A_MASK[8:2]];
  wire logic [7:0] req_b = irq_b_status_in & regs[OFS_IRQ_B_MASK[8:2]];
  wire logic [7:0] req_c = irq_c_status_in & regs[OFS_IRQ_C_MASK[8:2]];
  wire logic [7:0] req_d = irq_d_status_in & regs[OFS_IRQ_D_MASK[8:2]];
  wire logic [7:0] req_f = fast_irq_status_in & regs[OFS_FAST_IRQ_MASK[8:2]];

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  logic [15:0] t_count [PRD_NUM_TIMERS];
  logic [15:0] t_latched [PRD_NUM_TIMERS];
  logic [1:0] t_run;
  logic [15:0] t_reload [PRD_NUM_TIMERS];

  assign t_reload[0] = {regs[OFS_TIMER0_COUNT_HIGH[8:2]], regs[OFS_TIMER0_COUNT_LOW[8:2]]};
  assign t_reload[1] = {regs[OFS_TIMER1_COUNT_HIGH[8:2]], regs[OFS_TIMER1_COUNT_LOW[8:2]]};

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < PRD_NUM_TIMERS; i++) begin
        t_count[i] <= PRD_CNT_RST;
        t_latched[i] <= PRD_CNT_RST;
      end
      t_run <= 2'b00;
      timer_tick_out <= 2'b00;
    end else begin
      for (int i = 0; i < PRD_NUM_TIMERS; i++) begin
        timer_tick_out[i] <= 1'b0;
        if (wr_latch[i]) begin
          t_latched[i] <= t_count[i];  // RQ10
        end
        if (wr_go[i]) begin
          t_count[i] <= t_reload[i];  // RQ9
          t_run[i] <= 1'b1;
        end else if (t_run[i]) begin
          if (t_count[i] == PRD_CNT_RST) begin
            t_count[i] <= t_reload[i];
            timer_tick_out[i] <= 1'b1;
          end else begin
            t_count[i] <= t_count[i] - PRD_CNT_ONE;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = PRD_WORD_ZERO;
    case (ofs)
      OFS_IRQ_A_STATUS: rd_val[7:0] = irq_a_status_in;
      OFS_IRQ_A_REQUEST_CLEAR: rd_val[7:0] = req_a;
      OFS_IRQ_B_STATUS: rd_val[7:0] = irq_b_status_in;
      OFS_IRQ_B_REQUEST: rd_val[7:0] = req_b;
      OFS_FAST_IRQ_STATUS: rd_val[7:0] = fast_irq_status_in;
      OFS_FAST_IRQ_REQUEST: rd_val[7:0] = req_f;
      OFS_IRQ_C_STATUS: rd_val[7:0] = irq_c_status_in;
      OFS_IRQ_C_REQUEST: rd_val[7:0] = req_c;
      OFS_IRQ_D_STATUS: rd_val[7:0] = irq_d_status_in;
      OFS_IRQ_D_REQUEST: rd_val[7:0] = req_d;
      OFS_TIMER0_COUNT_LOW: rd_val[7:0] = t_latched[0][7:0];  // RQ10
      OFS_TIMER0_COUNT_HIGH: rd_val[7:0] = t_latched[0][15:8];
      OFS_TIMER1_COUNT_LOW: rd_val[7:0] = t_latched[1][7:0];
      OFS_TIMER1_COUNT_HIGH: rd_val[7:0] = t_latched[1][15:8];
      OFS_CHIP_IDENT_LOW: rd_val[7:0] = IDENT_LOW;
      OFS_CHIP_IDENT_HIGH: rd_val[7:0] = IDENT_HIGH;
      OFS_CHIP_REVISION: rd_val[7:0] = REVISION;
      OFS_ADC_STATUS: rd_val[7:0] = adc_status_in;
      OFS_ADC_COUNTER_ONE: rd_val[15:0] = adc_count_one_in;
      OFS_ADC_COUNTER_TWO: rd_val[15:0] = adc_count_two_in;
      OFS_ADC_COUNTER_THREE: rd_val[15:0] = adc_count_three_in;
      default: begin
        if (is_rw) begin
          rd_val[7:0] = regs[idx];  // RQ7
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer and command pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_rdata_out <= PRD_WORD_ZERO;
      bus_rvalid_out <= 1'b0;
      vs_wr_out <= 1'b0;
      vs_sel_out <= PRD_REG_RST;
      vs_data_out <= PRD_WORD_ZERO;
      irq_a_clear_out <= PRD_REG_RST;
      suspend_req_out <= 1'b0;
      stop_req_out <= 1'b0;
    end else begin
      bus_rvalid_out <= bus_rd_in;
      bus_rdata_out <= rd_p ? rd_val : PRD_WORD_ZERO;  // RQ3 RQ12
      vs_wr_out <= wr_vs;  // RQ1
      if (wr_vs) begin
        vs_sel_out <= bus_wdata_in[PRD_VS_SEL_MSB:PRD_VS_SEL_LSB];  // RQ2
        vs_data_out <= bus_wdata_in;
      end
      irq_a_clear_out <= wr_irq_a_clear ? low_byte(bus_wdata_in) : PRD_REG_RST;
      suspend_req_out <= wr_suspend;  // RQ7
      stop_req_out <= wr_stop;  // RQ8
    end
  end

  assign irq_pending_out = |{req_a, req_b, req_c, req_d};
  assign fast_irq_pending_out = |req_f;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence vs_write_s;
    bus_wr_in && in_vs;
  endsequence

  sequence vs_strobe_s(logic [7:0] sel);
    vs_wr_out && (vs_sel_out == sel);
  endsequence

  vs_select_a: assert property ( // RQ2
    vs_write_s |=> vs_strobe_s($past(bus_wdata_in[PRD_VS_SEL_MSB:PRD_VS_SEL_LSB]))
  ) else $error("macrocell select not taken from data top byte");

  vs_only_window_a: assert property ( // RQ1
    vs_wr_out |-> $past(bus_wr_in) && $past(in_vs)
  ) else $error("macrocell strobe without window write");

  vs_read_zero_a: assert property ( // RQ3
    (bus_rd_in && in_vs) |=> bus_rvalid_out && (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("macrocell read returned data");

  lines_store_a: assert property ( // RQ5
    (wr_p && (ofs == OFS_GENERAL_IO_LINES)) |=> (io_lines_out == $past(bus_wdata_in[7:0]))
  ) else $error("io lines register did not store low byte");

  ctrl_offset_a: assert property ( // RQ6
    (bus_wr_in && (bus_addr_in == PRD_PERIPH_BASE)) |=>
      (io_control_out == $past(bus_wdata_in[7:0]))
  ) else $error("base offset write missed io control");

  sequence suspend_wr_s;
    wr_p && (ofs == OFS_SUSPEND_ENTRY);
  endsequence

  suspend_entry_a: assert property ( // RQ7
    suspend_wr_s |=> suspend_req_out ##1 !suspend_req_out || $past(wr_suspend)
  ) else $error("suspend request not a single pulse");

  stop_entry_a: assert property ( // RQ8
    (stop_req_out == $past(wr_stop)) and (stop_req_out |-> ($past(ofs) == OFS_STOP_ENTRY))
  ) else $error("stop request not tied to stop write");

  sequence go_wr_s;
    wr_go[0] && !wr_go[1];
  endsequence

  timer_go_a: assert property ( // RQ9
    go_wr_s |=> t_run[0] && (t_count[0] == $past(t_reload[0]))
  ) else $error("timer 0 go did not load and start");

  timer_latch_a: assert property ( // RQ10
    wr_latch[1] |=> (t_latched[1] == $past(t_count[1]))
  ) else $error("timer 1 latch did not capture count");

  stop_read_zero_a: assert property ( // RQ8
    (rd_p && !is_rw && (ofs == OFS_STOP_ENTRY)) |=> (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("stop register read returned data");

  unmapped_write_a: assert property ( // RQ12
    (wr_p && !is_rw) |=> (io_control_out == $past(io_control_out))
  ) else $error("write to non-storing offset changed storage");

  rvalid_pulse_a: assert property ( // RQ12
    bus_rvalid_out == $past(bus_rd_in)
  ) else $error("read valid not one cycle after read");

  rdata_idle_a: assert property ( // RQ12
    !$past(bus_rd_in) |-> (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("read data not zero without read");

  outside_read_a: assert property ( // RQ12
    (bus_rd_in && !in_periph) |=> (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("read outside window returned data");

  sequence go_rd_s;
    rd_p && ((ofs == OFS_TIMER0_GO_CMD) || (ofs == OFS_TIMER1_GO_CMD));
  endsequence

  go_read_zero_a: assert property ( // RQ9
    go_rd_s |=> (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("timer go register read returned data");

  sequence latch_rd_s;
    rd_p && ((ofs == OFS_TIMER0_LATCH_CMD) || (ofs == OFS_TIMER1_LATCH_CMD));
  endsequence

  latch_read_zero_a: assert property ( // RQ10
    latch_rd_s |=> (bus_rdata_out == PRD_WORD_ZERO)
  ) else $error("timer latch register read returned data");

  suspend_read_a: assert property ( // RQ7
    (rd_p && (ofs == OFS_SUSPEND_ENTRY)) |=>
      (bus_rdata_out[7:0] == $past(regs[OFS_SUSPEND_ENTRY[8:2]]))
  ) else $error("suspend register did not read back");

  vs_data_a: assert property ( // RQ2
    vs_write_s |=> (vs_data_out == $past(bus_wdata_in))
  ) else $error("macrocell data word not passed whole");

  vs_hold_a: assert property ( // RQ1
    !wr_vs |=> $stable(vs_sel_out) && $stable(vs_data_out)
  ) else $error("macrocell outputs changed without write");

  vs_no_side_a: assert property ( // RQ1
    wr_vs |=> !suspend_req_out && !stop_req_out && $stable(io_control_out)
  ) else $error("macrocell write touched peripheral side");

  clear_pulse_a: assert property ( // RQ5
    irq_a_clear_out ==
      ($past(wr_irq_a_clear) ? $past(bus_wdata_in[7:0]) : PRD_REG_RST)
  ) else $error("clear bits not a one cycle copy of low byte");

  unaligned_write_a: assert property ( // RQ5
    (bus_wr_in && !aligned && !in_vs) |=>
      $stable(io_lines_out) && $stable(io_control_out)
  ) else $error("unaligned write changed storage");

  ident_read_a: assert property ( // RQ6
    (rd_p && (ofs == OFS_CHIP_IDENT_LOW)) |=> (bus_rdata_out[7:0] == IDENT_LOW)
  ) else $error("ident low byte read wrong");

  timer_down_a: assert property ( // RQ9
    (t_run[0] && !wr_go[0] && (t_count[0] != PRD_CNT_RST)) |=>
      (t_count[0] == $past(t_count[0]) - PRD_CNT_ONE)
  ) else $error("timer 0 did not count down");

  timer_tick_a: assert property ( // RQ9
    timer_tick_out[0] |-> $past(t_run[0]) && (t_count[0] == $past(t_reload[0]))
  ) else $error("timer 0 tick without reload");

  latch_hold_a: assert property ( // RQ10
    !wr_latch[0] |=> $stable(t_latched[0])
  ) else $error("timer 0 latch changed without command");

  latch_read_a: assert property ( // RQ10
    (rd_p && (ofs == OFS_TIMER1_COUNT_LOW)) |=>
      (bus_rdata_out[7:0] == $past(t_latched[1][7:0]))
  ) else $error("timer 1 low read not the latched count");

endmodule

// [tb/test_peripheral_register_map_decode.sv]
// Self-checking testbench for the peripheral register bank
module test_peripheral_register_map_decode
  import prd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [31:0] bus_addr_in = 32'h0;
  logic [31:0] bus_wdata_in = 32'h0;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic [31:0] bus_rdata_out;
  logic bus_rvalid_out;
  logic [7:0] st_a = 8'h0, st_b = 8'h0, st_c = 8'h0, st_d = 8'h0, st_f = 8'h0, st_adc = 8'h0;
  logic [15:0] cnt1 = 16'h0, cnt2 = 16'h0, cnt3 = 16'h0;
  logic vs_wr_out, suspend_req_out, stop_req_out, irq_pending_out, fast_irq_pending_out;
  logic [7:0] vs_sel_out, irq_a_clear_out, io_control_out, io_lines_out;
  logic [31:0] vs_data_out;
  logic [1:0] timer_tick_out;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] q, d, a;
  logic [8:0] rw_ofs [20] = '{9'h004, 9'h008, 9'h00C, 9'h018, 9'h028, 9'h038, 9'h068, 9'h06C,
    9'h078, 9'h080, 9'h084, 9'h08C, 9'h0A8, 9'h0AC, 9'h0C4, 9'h0C8, 9'h0CC, 9'h0D0, 9'h0E0,
    9'h0E8};
  logic [31:0] bad_addr [6] = '{32'h0320_003C, 32'h0320_00F8, 32'h0320_0180, 32'h0320_01F8,
    32'h0320_000D, 32'h0320_0200};

  prd_regbank #(.IDENT_LOW(8'h3C), .IDENT_HIGH(8'hC3), .REVISION(8'h07)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .bus_rvalid_out(bus_rvalid_out),
    .irq_a_status_in(st_a), .irq_b_status_in(st_b), .irq_c_status_in(st_c),
    .irq_d_status_in(st_d), .fast_irq_status_in(st_f), .adc_status_in(st_adc),
    .adc_count_one_in(cnt1), .adc_count_two_in(cnt2), .adc_count_three_in(cnt3),
    .vs_wr_out(vs_wr_out), .vs_sel_out(vs_sel_out), .vs_data_out(vs_data_out),
    .irq_a_clear_out(irq_a_clear_out), .irq_pending_out(irq_pending_out),
    .fast_irq_pending_out(fast_irq_pending_out), .suspend_req_out(suspend_req_out),
    .stop_req_out(stop_req_out), .timer_tick_out(timer_tick_out),
    .io_control_out(io_control_out), .io_lines_out(io_lines_out));

  always #20 sys_clk_in = ~sys_clk_in;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pa(input logic [8:0] ofs);
    return PRD_PERIPH_BASE + {23'h0, ofs};
  endfunction

  function automatic logic [31:0] low8(input logic [31:0] v);
    return {24'h0, v[7:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    @(negedge sys_clk_in);
    bus_addr_in = adr;
    bus_wdata_in = dat;
    bus_wr_in = 1'b1;
    @(negedge sys_clk_in);
    bus_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [31:0] adr, output logic [31:0] dat);
    @(negedge sys_clk_in);
    bus_addr_in = adr;
    bus_rd_in = 1'b1;
    @(negedge sys_clk_in);
    bus_rd_in = 1'b0;
    chk({31'h0, bus_rvalid_out}, 32'h1, "rvalid");
    dat = bus_rdata_out;
  endtask

  task automatic results();
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h68C8));
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    chk({24'h0, io_control_out}, 32'h0B, "io_control reset");
    chk({24'h0, io_lines_out}, 32'hFF, "io_lines reset");
    for (int i = 0; i < 40; i++) begin
      a = pa(rw_ofs[i % 20]);
      d = $urandom;
      wr(a, d);
      rd(a, q);
      chk(q, low8(d), "rw readback");
    end
    d = $urandom;
    wr(pa(OFS_IO_CONTROL), d);
    chk({24'h0, io_control_out}, low8(d), "io_control out");
    d = 32'hA5A5_A55A;
    wr(pa(OFS_GENERAL_IO_LINES), d);
    chk({24'h0, io_lines_out}, 32'h5A, "io_lines out");
    foreach (bad_addr[i]) begin
      wr(bad_addr[i], $urandom);
      rd(bad_addr[i], q);
      chk(q, 32'h0, "unmapped read");
    end
    chk({24'h0, io_lines_out}, 32'h5A, "io_lines kept");
    for (int i = 0; i < 12; i++) begin
      a = PRD_VS_BASE + ($urandom & 32'h000F_FFFF);
      d = (i == 0) ? 32'hFF00_0000 : $urandom;
      wr(a, d);
      chk({31'h0, vs_wr_out}, 32'h1, "vs strobe");
      chk({24'h0, vs_sel_out}, {24'h0, d[31:24]}, "vs select");
      chk(vs_data_out, d, "vs data");
      rd(a, q);
      chk(q, 32'h0, "vs read");
    end
    wr(PRD_VS_LAST + 32'h1, 32'h1200_0000);
    chk({31'h0, vs_wr_out}, 32'h0, "vs outside");
    st_a = 8'($urandom);
    st_b = 8'($urandom);
    st_c = 8'($urandom);
    st_d = 8'($urandom);
    st_f = 8'($urandom);
    st_adc = 8'($urandom);
    cnt1 = 16'($urandom);
    cnt2 = 16'($urandom);
    cnt3 = 16'($urandom);
    wr(pa(OFS_IRQ_A_STATUS), 32'hFF);
    rd(pa(OFS_IRQ_A_STATUS), q);
    chk(q, {24'h0, st_a}, "status a");
    rd(pa(OFS_IRQ_B_STATUS), q);
    chk(q, {24'h0, st_b}, "status b");
    rd(pa(OFS_IRQ_C_STATUS), q);
    chk(q, {24'h0, st_c}, "status c");
    rd(pa(OFS_IRQ_D_STATUS), q);
    chk(q, {24'h0, st_d}, "status d");
    rd(pa(OFS_FAST_IRQ_STATUS), q);
    chk(q, {24'h0, st_f}, "status fast");
    rd(pa(OFS_ADC_STATUS), q);
    chk(q, {24'h0, st_adc}, "adc status");
    rd(pa(OFS_ADC_COUNTER_ONE), q);
    chk(q, {16'h0, cnt1}, "adc count 1");
    rd(pa(OFS_ADC_COUNTER_TWO), q);
    chk(q, {16'h0, cnt2}, "adc count 2");
    rd(pa(OFS_ADC_COUNTER_THREE), q);
    chk(q, {16'h0, cnt3}, "adc count 3");
    rd(pa(OFS_CHIP_IDENT_LOW), q);
    chk(q, 32'h3C, "ident low");
    rd(pa(OFS_CHIP_IDENT_HIGH), q);
    chk(q, 32'hC3, "ident high");
    rd(pa(OFS_CHIP_REVISION), q);
    chk(q, 32'h07, "revision");
    d = $urandom;
    wr(pa(OFS_IRQ_A_MASK), d);
    rd(pa(OFS_IRQ_A_REQUEST_CLEAR), q);
    chk(q, {24'h0, st_a & d[7:0]}, "request a");
    d = $urandom;
    wr(pa(OFS_IRQ_A_REQUEST_CLEAR), d);
    chk({24'h0, irq_a_clear_out}, low8(d), "clear a");
    st_b = 8'h0;
    st_c = 8'h0;
    st_d = 8'h0;
    st_a = 8'h04;
    st_f = 8'h80;
    wr(pa(OFS_IRQ_A_MASK), 32'h04);
    wr(pa(OFS_FAST_IRQ_MASK), 32'h7F);
    chk({30'h0, irq_pending_out, fast_irq_pending_out}, 32'h2, "pending on");
    wr(pa(OFS_IRQ_A_MASK), 32'hFB);
    wr(pa(OFS_FAST_IRQ_MASK), 32'h80);
    chk({30'h0, irq_pending_out, fast_irq_pending_out}, 32'h1, "pending mask");
    d = $urandom;
    wr(pa(OFS_SUSPEND_ENTRY), d);
    chk({30'h0, suspend_req_out, stop_req_out}, 32'h2, "suspend pulse");
    rd(pa(OFS_SUSPEND_ENTRY), q);
    chk(q, low8(d), "suspend readback");
    wr(pa(OFS_STOP_ENTRY), $urandom);
    chk({30'h0, suspend_req_out, stop_req_out}, 32'h1, "stop pulse");
    wr(pa(OFS_TIMER0_COUNT_LOW), 32'h10);
    wr(pa(OFS_TIMER0_COUNT_HIGH), 32'h00);
    wr(pa(OFS_TIMER0_GO_CMD), $urandom);
    rd(pa(OFS_TIMER0_GO_CMD), q);
    chk(q, 32'h0, "go read");
    d = 32'h0;
    for (int i = 0; i < 60 && d == 32'h0; i++) begin
      @(negedge sys_clk_in);
      if (timer_tick_out[0] === 1'b1) begin
        d = 32'h1;
      end
    end
    chk(d, 32'h1, "timer0 tick");
    wr(pa(OFS_TIMER1_COUNT_LOW), 32'h00);
    wr(pa(OFS_TIMER1_COUNT_HIGH), 32'h01);
    wr(pa(OFS_TIMER1_GO_CMD), 32'h0);
    repeat (10) @(negedge sys_clk_in);
    wr(pa(OFS_TIMER1_LATCH_CMD), 32'h0);
    rd(pa(OFS_TIMER1_COUNT_LOW), q);
    rd(pa(OFS_TIMER1_COUNT_HIGH), d);
    a = {16'h0, d[7:0], q[7:0]};
    chk({31'h0, a < 32'h100 && a > 32'hE0}, 32'h1, "latched count");
    rd(pa(OFS_TIMER1_LATCH_CMD), q);
    chk(q, 32'h0, "latch read");
    rd(pa(OFS_TIMER0_LATCH_CMD), q);
    chk(q, 32'h0, "latch0 read");
    rd(pa(OFS_TIMER1_GO_CMD), q);
    chk(q, 32'h0, "go1 read");
    rd(pa(OFS_STOP_ENTRY), q);
    chk(q, 32'h0, "stop read");
    results();
  end
endmodule
